// ---- logic/qp_pkg.sv ----
// Shared constants for the quad serial-loaded PWM link and both ends
// Notes on behaviour
// [R1] Controller sends command byte before upper byte
// [R2] New settings take effect next cycle only
// [R3] Cycle is 4096 ticks, sixteen subsections
// [R4] Subsection is 256 ticks; tick two osc periods
// [R5] Upper eight bits set base high time
// [R6] Low four bits pick subsections for extra tick
// [R7] Codes 1,2,4,8 pick fixed subsection sets
// [R8] Float request high floats outputs next cycle
// [R9] Reset low: finish cycle, float, clear values
// [R10] After reset, channel drives only once rewritten
// [R11] Strobe, data, shift clock need chip select low
// [R12] Shift while strobe low; latch on strobe rise
// [R13] Each byte is eight bits clocked serially
// [R14] Tick runs at half the oscillator rate
// [R15] Upper byte carries value[11:4], command[7:4] value[3:0]
// [R16] Command bits 2 and 1 choose channel
// [R17] Bit3/bit0 choose low update, full update, disable
// [R18] Data sampled on shift clock rising edge
// [R19] Strobe rise copies collected data into channel
// [R20] Disable clears stored bit 0; no upper byte
// [R21] Float request sampled once per cycle start
// [R22] Other codes stretch the union of sets
// [R23] High for base plus stretch, then low
// [R24] Channel code 00 is first, 11 fourth
package qp_pkg;
   localparam int unsigned CORE_PERIOD_NS = 100;
   localparam int unsigned SCLK_PERIOD_NS = 800;
   localparam int unsigned SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
   localparam int unsigned OSC_PER_TICK   = 2;
   localparam int unsigned CHANNELS       = 4;
   localparam int unsigned SUB_BITS       = 4;
   localparam int unsigned TICK_BITS      = 8;
   localparam int unsigned CYCLE_BITS     = SUB_BITS + TICK_BITS;
   localparam int unsigned VALUE_BITS     = 12;
   localparam int unsigned BYTE_BITS      = 8;
   localparam int unsigned SYNC_W         = 6;
   // Command byte layout
   localparam int unsigned CMD_FULL_BIT   = 0;
   localparam int unsigned CMD_CH_LSB     = 1;
   localparam int unsigned CMD_ENABLE_BIT = 3;
   localparam int unsigned CMD_LOW_LSB    = 4;
   // Controller register map, one word each
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_CMD    = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam int unsigned CTRL_FLOAT_BIT = 0;
   localparam int unsigned CTRL_RESET_BIT = 1;
   localparam int unsigned FIELD_CH_LSB   = 12;
   localparam int unsigned FIELD_MODE_LSB = 14;
   localparam logic [1:0] MODE_LOW  = 2'h0;
   localparam logic [1:0] MODE_FULL = 2'h1;
   localparam logic [1:0] MODE_OFF  = 2'h2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- logic/qp_link_if.sv ----
// Serial load link and tri-state pulse outputs between controller and device
`timescale 1ns/1ps
`default_nettype none
interface qp_link_if;
   logic       cs_n;
   logic       wr_n;
   logic       sclk;
   logic       serial_in;
   logic       output_float_request;
   logic       chip_reset_n;
   logic [3:0] pulse_outputs;
   logic [3:0] pulse_oe;
   modport ctrl (
      output cs_n, wr_n, sclk, serial_in, output_float_request, chip_reset_n,
      input  pulse_outputs, pulse_oe
   );
   modport dev (
      input  cs_n, wr_n, sclk, serial_in, output_float_request, chip_reset_n,
      output pulse_outputs, pulse_oe
   );
endinterface
`default_nettype wire

// ---- logic/qp_pwm_device.sv ----
// Four-channel 12-bit PWM device with write-only serial loading
`timescale 1ns/1ps
`default_nettype none
module qp_pwm_device #(
   parameter int unsigned CH = qp_pkg::CHANNELS
) (
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic reset_n_in,
   // Link
   qp_link_if.dev    link
);
   localparam int unsigned SB = qp_pkg::SUB_BITS;
   localparam int unsigned TB = qp_pkg::TICK_BITS;
   localparam int unsigned CB = qp_pkg::CYCLE_BITS;
   localparam int unsigned VB = qp_pkg::VALUE_BITS;
   localparam int unsigned BB = qp_pkg::BYTE_BITS;
   localparam logic [CB-1:0] CYCLE_LAST = '1;
   localparam logic [1:0] DIV_LAST = 2'(qp_pkg::OSC_PER_TICK - 1);

   // Bit order of the synchroniser vectors
   localparam int unsigned S_CS = 0;
   localparam int unsigned S_WR = 1;
   localparam int unsigned S_CK = 2;
   localparam int unsigned S_DI = 3;
   localparam int unsigned S_OC = 4;
   localparam int unsigned S_RS = 5;
   localparam logic [qp_pkg::SYNC_W-1:0] SYNC_IDLE = 6'h23; // Idle pin levels

   logic [qp_pkg::SYNC_W-1:0] sync1_reg;
   logic [qp_pkg::SYNC_W-1:0] sync2_reg;
   logic                      sclk_d_reg;
   logic                      wr_d_reg;
   logic [1:0]                div_reg;
   logic                      tick_en;
   logic [CB-1:0]             cnt_reg;
   logic                      cycle_end;
   logic                      halted_reg;
   logic [BB-1:0]             shift_reg;
   logic [BB-1:0]             command_low_byte_reg;
   logic [BB-1:0]             value_high_byte_reg;
   logic                      upper_pending_reg;
   logic [VB-1:0]             channel_duty_value_reg [CH];
   logic [CH-1:0]             enable_reg;
   logic [VB-1:0]             active_value_reg [CH];
   logic [CH-1:0]             active_en_reg;
   logic                      float_reg;
   logic [CH-1:0]             pulse_reg;
   logic [CH-1:0]             oe_reg;
   logic                      sel_low;
   logic                      shift_edge;
   logic                      strobe_edge;
   logic [1:0]                cmd_ch;

   // Pins come from another domain: two flops before any use
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         sync1_reg <= SYNC_IDLE;
         sync2_reg <= SYNC_IDLE;
      end else begin
         sync1_reg <= {link.chip_reset_n, link.output_float_request, link.serial_in,
                       link.sclk, link.wr_n, link.cs_n};
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         sclk_d_reg <= 1'b0;
         wr_d_reg   <= 1'b1;
      end else begin
         sclk_d_reg <= sync2_reg[S_CK];
         wr_d_reg   <= sync2_reg[S_WR];
      end
   end

   assign sel_low     = !sync2_reg[S_CS] && !halted_reg;                       // R11
   assign shift_edge  = sel_low && !sync2_reg[S_WR] && sync2_reg[S_CK] && !sclk_d_reg; // R18
   assign strobe_edge = sel_low && sync2_reg[S_WR] && !wr_d_reg;               // R12

   // Tick is every second core clock
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         div_reg <= '0;
      end else if (div_reg == DIV_LAST) begin
         div_reg <= '0;                                                        // R14
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end
   assign tick_en   = (div_reg == DIV_LAST);                                   // R4
   assign cycle_end = tick_en && (cnt_reg == CYCLE_LAST);

   // Cycle counter: top bits are subsection, low bits tick within it
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || halted_reg) begin
         cnt_reg <= '0;                                                        // R10
      end else if (tick_en) begin
         cnt_reg <= cnt_reg + 1'b1;                                            // R3
      end
   end

   // Reset pin acts only at a cycle boundary, released at once
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         halted_reg <= 1'b0;
      end else if (halted_reg) begin
         halted_reg <= !sync2_reg[S_RS];                                       // R10
      end else if (cycle_end && !sync2_reg[S_RS]) begin
         halted_reg <= 1'b1;                                                   // R9
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         shift_reg <= '0;
      end else if (shift_edge) begin
         shift_reg <= {shift_reg[BB-2:0], sync2_reg[S_DI]};                    // R13
      end
   end

   assign cmd_ch = command_low_byte_reg[qp_pkg::CMD_CH_LSB +: 2];

   // Byte latch; a pending full command makes the next byte the upper one
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || halted_reg) begin
         command_low_byte_reg <= '0;
         value_high_byte_reg  <= '0;
         upper_pending_reg    <= 1'b0;
      end else if (strobe_edge) begin
         if (upper_pending_reg) begin
            value_high_byte_reg <= shift_reg;                                  // R12
            upper_pending_reg   <= 1'b0;
         end else begin
            command_low_byte_reg <= shift_reg;
            // Disable clears the stored full-write flag
            upper_pending_reg <= shift_reg[qp_pkg::CMD_ENABLE_BIT] &&
                                 shift_reg[qp_pkg::CMD_FULL_BIT];             // R20
            if (!shift_reg[qp_pkg::CMD_ENABLE_BIT]) begin
               command_low_byte_reg[qp_pkg::CMD_FULL_BIT] <= 1'b0;           // R20
            end
         end
      end
   end

   // Staged channel values; copied to the waveform only at cycle end
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || halted_reg) begin
         for (int i = 0; i < CH; i++) begin
            channel_duty_value_reg[i] <= '0;                                   // R9
         end
         enable_reg <= '0;                                                     // R10
      end else if (strobe_edge) begin
         if (upper_pending_reg) begin
            channel_duty_value_reg[cmd_ch] <= {shift_reg,
               command_low_byte_reg[qp_pkg::CMD_LOW_LSB +: 4]};                // R15 R19
            enable_reg[cmd_ch] <= 1'b1;                                        // R17
         end else if (!shift_reg[qp_pkg::CMD_ENABLE_BIT]) begin
            enable_reg[shift_reg[qp_pkg::CMD_CH_LSB +: 2]] <= 1'b0;            // R17 R24
         end else if (!shift_reg[qp_pkg::CMD_FULL_BIT]) begin
            channel_duty_value_reg[shift_reg[qp_pkg::CMD_CH_LSB +: 2]][3:0] <=
               shift_reg[qp_pkg::CMD_LOW_LSB +: 4];                            // R16 R19
            enable_reg[shift_reg[qp_pkg::CMD_CH_LSB +: 2]] <= 1'b1;            // R17
         end
      end
   end

   // Active copies; a write mid-cycle cannot disturb the running waveform
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || halted_reg) begin
         for (int i = 0; i < CH; i++) begin
            active_value_reg[i] <= '0;
         end
         active_en_reg <= '0;
         float_reg     <= 1'b1;
      end else if (cycle_end) begin
         for (int i = 0; i < CH; i++) begin
            active_value_reg[i] <= channel_duty_value_reg[i];                  // R2
         end
         active_en_reg <= enable_reg;                                          // R2
         float_reg     <= sync2_reg[S_OC];                                     // R8 R21
      end
   end

   // True when subsection m gets the extra tick for low code c
   function automatic logic stretched(input logic [SB-1:0] m, input logic [3:0] c);
      logic hit;
      hit = 1'b0;
      // Code bit 3-k owns the subsections whose lowest set bit is bit k
      for (int k = 0; k < SB; k++) begin
         if (m[k] && (m & ((SB'(1) << k) - SB'(1))) == '0) begin
            hit = c[SB-1-k];                                                   // R7 R22
         end
      end
      return hit;
   endfunction

   // Per-channel waveform and tri-state control
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         pulse_reg <= '0;
         oe_reg    <= '0;
      end else begin
         for (int i = 0; i < CH; i++) begin
            pulse_reg[i] <= ({1'b0, cnt_reg[TB-1:0]} <
                            ({1'b0, active_value_reg[i][VB-1 -: TB]} +         // R5 R23
                             (TB+1)'(stretched(cnt_reg[CB-1 -: SB],
                                               active_value_reg[i][3:0])))); // R6
            oe_reg[i]    <= active_en_reg[i] && !float_reg && !halted_reg;     // R8 R9
         end
      end
   end

   assign link.pulse_outputs = pulse_reg;
   assign link.pulse_oe      = oe_reg;
endmodule
`default_nettype wire

// ---- logic/qp_pwm_ctrl.sv ----
// Serial controller for the PWM device, commanded over AXI4-Lite
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module qp_pwm_ctrl (
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   // AXI4-Lite write
   input  wire logic [3:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // AXI4-Lite read
   input  wire logic [3:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // Link
   qp_link_if.ctrl          link
);
   typedef enum logic [2:0] {
      QP_IDLE, QP_SELECT, QP_BIT_LO, QP_BIT_HI, QP_END_BYTE, QP_REARM, QP_RELEASE
   } qp_state_e;

   localparam logic [2:0] HALF_LAST = 3'(qp_pkg::SCLK_HALF_CYC - 1);
   localparam logic [2:0] BIT_LAST  = 3'(qp_pkg::BYTE_BITS - 1);

   qp_state_e   state_reg;
   logic [2:0]  half_reg;
   logic        half_en;
   logic [2:0]  bit_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  upper_reg;
   logic        more_reg;
   logic        go_reg;
   logic [15:0] cmd_reg;
   logic [1:0]  ctrl_reg;
   logic        cs_n_reg;
   logic        wr_n_reg;
   logic        sclk_reg;
   logic        sdo_reg;
   logic [3:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;
   logic        do_write;
   logic        cmd_hit;

   assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
   assign cmd_hit  = do_write && aw_addr_reg == qp_pkg::REG_CMD && state_reg == QP_IDLE
                     && !go_reg;

   // Write channel: address and data taken in either order
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= qp_pkg::RESP_OKAY;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
      end else begin
         if (s_axi_awvalid_in && awready_reg) begin
            awready_reg <= 1'b0;
            aw_addr_reg <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && wready_reg) begin
            wready_reg <= 1'b0;
            w_data_reg <= s_axi_wdata_in;
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (aw_addr_reg == qp_pkg::REG_CTRL || aw_addr_reg == qp_pkg::REG_CMD)
                          ? qp_pkg::RESP_OKAY : qp_pkg::RESP_SLVERR;
         end
         if (bvalid_reg && s_axi_bready_in) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // Byte strobes ignored: registers are whole-word only
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         ctrl_reg <= '0;
         cmd_reg  <= '0;
         go_reg   <= 1'b0;
      end else begin
         if (do_write && aw_addr_reg == qp_pkg::REG_CTRL) begin
            ctrl_reg <= w_data_reg[1:0];
         end
         // A command written while busy is dropped
         if (cmd_hit) begin
            cmd_reg <= w_data_reg[15:0];
            go_reg  <= 1'b1;
         end else if (state_reg == QP_IDLE && half_en) begin
            go_reg <= 1'b0;
         end
      end
   end

   // Read channel, answered one cycle after the address
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= qp_pkg::RESP_OKAY;
         rdata_reg   <= '0;
      end else if (s_axi_arvalid_in && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rresp_reg   <= qp_pkg::RESP_OKAY;
         unique case (s_axi_araddr_in)
            qp_pkg::REG_CTRL:   rdata_reg <= {30'h0, ctrl_reg};
            qp_pkg::REG_CMD:    rdata_reg <= {16'h0, cmd_reg};
            qp_pkg::REG_STATUS: rdata_reg <= {31'h0, (state_reg != QP_IDLE) || go_reg};
            default: begin
               rdata_reg <= '0;
               rresp_reg <= qp_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready_in) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // Shift clock half-period enable
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || half_reg == HALF_LAST) begin
         half_reg <= '0;
      end else begin
         half_reg <= half_reg + 3'h1;
      end
   end
   assign half_en = (half_reg == HALF_LAST);

   // Serial sequencer: one command byte, optionally followed by the upper byte
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         state_reg <= QP_IDLE;
         cs_n_reg  <= 1'b1;
         wr_n_reg  <= 1'b1;
         sclk_reg  <= 1'b0;
         sdo_reg   <= 1'b0;
         bit_reg   <= '0;
         shift_reg <= '0;
         upper_reg <= '0;
         more_reg  <= 1'b0;
      end else if (half_en) begin
         unique case (state_reg)
            QP_IDLE: if (go_reg) begin
               // Command byte always leads, even for upper-only changes
               shift_reg <= {cmd_reg[3:0],                                     // R1 R15
                             cmd_reg[qp_pkg::FIELD_MODE_LSB +: 2] != qp_pkg::MODE_OFF,
                             cmd_reg[qp_pkg::FIELD_CH_LSB +: 2],
                             cmd_reg[qp_pkg::FIELD_MODE_LSB +: 2] == qp_pkg::MODE_FULL}; // R17
               upper_reg <= cmd_reg[11:4];                                     // R15
               // Upper byte never follows a disable
               more_reg  <= cmd_reg[qp_pkg::FIELD_MODE_LSB +: 2] == qp_pkg::MODE_FULL; // R20
               cs_n_reg  <= 1'b0;                                              // R11
               state_reg <= QP_SELECT;
            end
            QP_SELECT: begin
               wr_n_reg  <= 1'b0;                                              // R12
               state_reg <= QP_BIT_LO;
            end
            QP_BIT_LO: begin
               sclk_reg  <= 1'b0;
               sdo_reg   <= shift_reg[7];                                      // R13
               state_reg <= QP_BIT_HI;
            end
            QP_BIT_HI: begin
               sclk_reg  <= 1'b1;                                              // R13
               shift_reg <= {shift_reg[6:0], 1'b0};
               bit_reg   <= bit_reg + 3'h1;
               state_reg <= (bit_reg == BIT_LAST) ? QP_END_BYTE : QP_BIT_LO;
            end
            QP_END_BYTE: begin
               sclk_reg  <= 1'b0;
               wr_n_reg  <= 1'b1;                                              // R12
               state_reg <= more_reg ? QP_REARM : QP_RELEASE;
            end
            QP_REARM: begin
               shift_reg <= upper_reg;
               more_reg  <= 1'b0;
               wr_n_reg  <= 1'b0;
               state_reg <= QP_BIT_LO;
            end
            QP_RELEASE: begin
               cs_n_reg  <= 1'b1;
               state_reg <= QP_IDLE;
            end
         endcase
      end
   end

   assign link.cs_n                 = cs_n_reg;
   assign link.wr_n                 = wr_n_reg;
   assign link.sclk                 = sclk_reg;
   assign link.serial_in            = sdo_reg;
   assign link.output_float_request = ctrl_reg[qp_pkg::CTRL_FLOAT_BIT];
   assign link.chip_reset_n         = !ctrl_reg[qp_pkg::CTRL_RESET_BIT];      // R10

   assign s_axi_awready_out = awready_reg;
   assign s_axi_wready_out  = wready_reg;
   assign s_axi_bvalid_out  = bvalid_reg;
   assign s_axi_bresp_out   = bresp_reg;
   assign s_axi_arready_out = arready_reg;
   assign s_axi_rvalid_out  = rvalid_reg;
   assign s_axi_rresp_out   = rresp_reg;
   assign s_axi_rdata_out   = rdata_reg;
endmodule
`default_nettype wire

// ---- sim/qp_link_assertions.sv ----
// Link and output checks for the PWM controller and device
`timescale 1ns/1ps
`default_nettype none
module qp_link_assertions (
   input wire logic       core_clk_in,
   input wire logic       reset_n_in,
   input wire logic       cs_n,
   input wire logic       wr_n,
   input wire logic       sclk,
   input wire logic       serial_in,
   input wire logic       output_float_request,
   input wire logic       chip_reset_n,
   input wire logic [3:0] pulse_outputs,
   input wire logic [3:0] pulse_oe
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   logic        p0_reg, seen_reg, rise;
   logic [15:0] gap_reg, fl_reg, rs_reg;
   assign rise = pulse_outputs[0] && !p0_reg;
   // Float and halt wait for a cycle end plus sync, hence 8300
   always_ff @(posedge core_clk_in) begin
      p0_reg   <= pulse_outputs[0];
      gap_reg  <= rise ? 16'h1 : gap_reg + 16'h1;
      seen_reg <= reset_n_in && chip_reset_n && (seen_reg || rise);
      fl_reg   <= output_float_request ? fl_reg + {15'h0, fl_reg < 16'h4000} : 16'h0;
      rs_reg   <= !chip_reset_n ? rs_reg + {15'h0, rs_reg < 16'h4000} : 16'h0;
   end
   sel_strobe_a: assert property (!wr_n |-> !cs_n)
      else $error("strobe low unselected");
   sel_shift_a: assert property (cs_n |-> !sclk)
      else $error("shift clock high unselected");
   shift_edge_a: assert property ($rose(sclk) |-> !wr_n && $stable(serial_in))
      else $error("bad shift edge");
   latch_edge_a: assert property ($rose(wr_n) |-> !cs_n && !sclk)
      else $error("bad strobe rise");
   byte_frame_a: assert property ($fell(wr_n) |-> !wr_n [*8])
      else $error("strobe too short");
   sub_grid_a: assert property (rise && seen_reg |-> gap_reg[8:0] == 9'h0)
      else $error("pulse off subsection grid");
   float_off_a: assert property (fl_reg > 16'd8300 |-> pulse_oe == 4'h0)
      else $error("driven while floated");
   halt_off_a: assert property (rs_reg > 16'd8300 |-> (pulse_oe | pulse_outputs) == 4'h0)
      else $error("active while in reset");
   cover property ($rose(wr_n));
   cover property (pulse_oe == 4'hf);
   cover property (rs_reg > 16'd8300);
endmodule
`default_nettype wire

// ---- sim/quad_12bit_serial_pwm_bench.sv ----
// Bench: PWM controller and device joined over the link
`timescale 1ns/1ps
`default_nettype none
module quad_12bit_serial_pwm_bench;
   logic        clk, rst_n, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, ck;
   logic [3:0]  aa;
   logic [31:0] wd, rd, last;
   logic [1:0]  br, rr;
   logic [33:0] exp_q[$], obs_v;
   logic [7:0]  base[4];
   logic [3:0]  code[4] = '{4'h4, 4'h1, 4'h2, 4'hf};
   integer      seed = 32'h557af097;
   int          error_cnt = 0, check_count = 0;
   event        obs_ev;
   qp_link_if link ();
   qp_pwm_ctrl i_qp_pwm_ctrl (.core_clk_in(clk), .reset_n_in(rst_n), .s_axi_awaddr_in(aa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
      .s_axi_araddr_in(aa), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rry), .link(link.ctrl));
   qp_pwm_device i_qp_pwm_device (.core_clk_in(clk), .reset_n_in(rst_n), .link(link.dev));
   qp_link_assertions i_qp_link_assertions (.core_clk_in(clk), .reset_n_in(rst_n),
      .cs_n(link.cs_n), .wr_n(link.wr_n), .sclk(link.sclk), .serial_in(link.serial_in),
      .output_float_request(link.output_float_request), .chip_reset_n(link.chip_reset_n),
      .pulse_outputs(link.pulse_outputs), .pulse_oe(link.pulse_oe));
   always #50 clk = ~clk;
   task automatic summarize;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic fail;
      error_cnt++;
      $display("Error %0t wait ran out exp %h got %h", $time, 1'b1, 1'b0);
      summarize();
   endtask
   task automatic check(input logic [33:0] got);
      logic [33:0] e;
      e = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
      check_count++;
      if (got !== e) begin
         error_cnt++;
         $display("Error %0t exp %h got %h", $time, e, got);
      end
   endtask
   always @(obs_ev) check(obs_v);
   always @(posedge clk)
      if (ck && ((bv && bry) || (rv && rry))) check(bv ? {br, 32'h0} : {rr, rd});
   task automatic axi(input logic w, c, logic [3:0] a, logic [31:0] d, logic [33:0] e);
      int n = 0;
      @(posedge clk);
      if (c) exp_q.push_back(e);
      ck <= c;
      aa <= a;
      wd <= d;
      {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
      do begin
         @(posedge clk);
         n++;
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         if (arr) arv <= 1'b0;
      end while (!(bv && bry || rv && rry) && n < 100);
      last = rd;
      {bry, rry, ck} <= 3'h0;
      if (n >= 100) fail();
   endtask
   task automatic cmd(input logic [1:0] ch, logic [1:0] m, logic [11:0] v);
      axi(1'b1, 1'b1, qp_pkg::REG_CMD, {16'h0, m, ch, v}, {qp_pkg::RESP_OKAY, 32'h0});
      last = 32'h1;
      for (int i = 0; i < 100 && last[0] !== 1'b0; i++)
         axi(1'b0, 1'b0, qp_pkg::REG_STATUS, 32'h0, 34'h0);
      if (last[0] !== 1'b0) fail();
   endtask
   // One cycle plus margin: settings only land at a cycle start
   task automatic oe_is(input logic [3:0] e);
      repeat (8300) @(posedge clk);
      exp_q.push_back({30'h0, e});
      obs_v = {30'h0, link.pulse_oe};
      ->obs_ev;
   endtask
   // Sum of 16 whole pulses is phase free: 2 clocks a tick
   task automatic measure(input int ch, logic [7:0] b, logic [3:0] c);
      int   n = 0, k = 0, s = 0, m = 0;
      logic p, q = 1'b0, lo = 1'b0;
      for (int i = 0; i < 16; i++)
         if ((c[3] && i % 2 == 1) || (c[2] && i % 4 == 2) || (c[1] && i % 8 == 4) || (c[0] && i == 8))
            m++;
      exp_q.push_back({2'h0, 32'(32 * b + 2 * m)});
      while (k < 16 && n < 20000) begin
         @(posedge clk);
         n++;
         p = link.pulse_outputs[ch];
         if (lo && p) s++;
         if (lo && q && !p) k++;
         lo = lo || !p;
         q = p;
      end
      if (k < 16) fail();
      obs_v = {2'h0, 32'(s)};
      ->obs_ev;
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {awv, wv, bry, arv, rry, ck, aa, wd} = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      axi(1'b0, 1'b1, qp_pkg::REG_STATUS, 32'h0, {qp_pkg::RESP_OKAY, 32'h0});
      axi(1'b0, 1'b1, 4'hc, 32'h0, {qp_pkg::RESP_SLVERR, 32'h0});
      axi(1'b1, 1'b1, 4'hc, 32'h3, {qp_pkg::RESP_SLVERR, 32'h0});
      axi(1'b1, 1'b1, qp_pkg::REG_CTRL, 32'h1, {qp_pkg::RESP_OKAY, 32'h0});
      axi(1'b0, 1'b1, qp_pkg::REG_CTRL, 32'h0, {qp_pkg::RESP_OKAY, 32'h1});
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         base[i] = 8'd1 + 8'($random(seed) & 32'h7f);
         cmd(2'(i), qp_pkg::MODE_FULL, {base[i], code[i]});
      end
      oe_is(4'h0);
      axi(1'b1, 1'b1, qp_pkg::REG_CTRL, 32'h0, {qp_pkg::RESP_OKAY, 32'h0});
      oe_is(4'hf);
      for (int i = 0; i < 4; i++) measure(i, base[i], code[i]);
      $display("test load done");
      cmd(2'h1, qp_pkg::MODE_LOW, 12'hff8);
      cmd(2'h2, qp_pkg::MODE_OFF, 12'h0);
      oe_is(4'hb);
      measure(1, base[1], 4'h8);
      $display("test update done");
      axi(1'b1, 1'b1, qp_pkg::REG_CTRL, 32'h2, {qp_pkg::RESP_OKAY, 32'h0});
      oe_is(4'h0);
      axi(1'b1, 1'b1, qp_pkg::REG_CTRL, 32'h0, {qp_pkg::RESP_OKAY, 32'h0});
      oe_is(4'h0);
      cmd(2'h3, qp_pkg::MODE_FULL, 12'h123);
      oe_is(4'h8);
      $display("test reset done");
      @(posedge clk);
      summarize();
   end
endmodule
`default_nettype wire
